//--- common/ebc_pkg.sv
// Operation
// (RULE1) Five phases in fixed order per access
// (RULE2) Phase lengths from per-chip-select timing registers
// (RULE3) Address setup 1-2 units, +0-3 on window change
// (RULE4) Command delay and hold each 0-3 units
// (RULE5) Write setup or tristate turnaround 0-1 unit
// (RULE6) Access 1-32 units, optionally stretched by ready
// (RULE7) Read data captured as strobe rises, address changes
// (RULE8) Module holds read data until strobe rises
// (RULE9) Multiplexed: address then write data on shared lines
// (RULE10) Separate mode: write data on dedicated data lines
// (RULE11) 24-bit address bus apart from shared lines
// (RULE12) Ready sampled in access: wait or end cycle
// (RULE13) Ready polarity, sync or async with extra stage; code adds two stages on the async path
// (RULE14) Module withdraws ready before next sample point
// (RULE15) Phases count whole bus time units from clock
package ebc_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int ADDR_W  = 24;
  localparam int DATA_W  = 16;
  localparam int NUM_CS  = 4;
  localparam int CS_W    = 2;
  localparam int AVM_AW  = 6;

  // ----------------------------------------
  // Register map (word byte addresses)
  // ----------------------------------------
  localparam logic [AVM_AW-1:0] REG_TIMING0 = 6'h00;
  localparam logic [AVM_AW-1:0] REG_ADDR    = 6'h10;
  localparam logic [AVM_AW-1:0] REG_WDATA   = 6'h14;
  localparam logic [AVM_AW-1:0] REG_CMD     = 6'h18;
  localparam logic [AVM_AW-1:0] REG_STATUS  = 6'h1C;
  localparam logic [AVM_AW-1:0] REG_RDATA   = 6'h20;
  localparam logic [AVM_AW-1:0] REG_PRESC   = 6'h24;
  localparam logic [7:0]        PRESC_RST   = 8'h00;

  // ----------------------------------------
  // Timing config field layout
  // ----------------------------------------
  localparam int F_AB   = 0;   // 1 bit: setup = 1 + field
  localparam int F_ABX  = 1;   // 2 bits: extra on window change
  localparam int F_C    = 3;   // 2 bits
  localparam int F_D    = 5;   // 1 bit
  localparam int F_E    = 6;   // 5 bits: access = 1 + field
  localparam int F_F    = 11;  // 2 bits
  localparam int F_MUX  = 13;  // multiplexed_bus_mode
  localparam int F_RDYE = 14;  // ready controlled
  localparam int F_RDYP = 15;  // ready active high
  localparam int F_RDYA = 16;  // asynchronous ready
  localparam int TCFG_W = 17;
  localparam logic [TCFG_W-1:0] TCFG_RST = 17'h007C1;

  // Window is this address bit and the bits above it
  localparam int WIN_LSB = 16;

  typedef struct packed {
    logic                    multiplexed_bus_mode;
    logic                    rdy_en;
    logic                    rdy_pol;
    logic                    rdy_async;
    logic [2:0]              len_ab;
    logic [1:0]              len_c;
    logic                    len_d;
    logic [5:0]              len_e;
    logic [1:0]              len_f;
  } phase_cfg_s;

  typedef struct packed {
    logic                    go;
    logic                    wr;
    logic                    bhe_n;
    logic [CS_W-1:0]         cs;
    logic [ADDR_W-1:0]       addr;
    logic [DATA_W-1:0]       wdata;
  } bus_req_s;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_AB   = 3'b001,
    PH_C    = 3'b010,
    PH_D    = 3'b011,
    PH_E    = 3'b100,
    PH_RDY  = 3'b101,
    PH_F    = 3'b110
  } phase_e;

endpackage

//--- rtl/ebc_time_unit.sv
`timescale 1ns/1ps
module ebc_time_unit
  import ebc_pkg::*;
(
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_arst_n,
  // Control
  input  wire logic [7:0] i_presc,
  input  wire logic       i_clear,
  output logic            o_tick
);

  logic [7:0] count;

  // ----------------------------------------
  // One tick per bus time unit
  // ----------------------------------------
  // Restart at each access so the first unit is a whole one
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count <= 8'h00;
    end else if (i_clear || count >= i_presc) begin
      count <= 8'h00;
    end else begin
      count <= count + 8'h01;
    end
  end

  assign o_tick = (count >= i_presc); // RULE15

endmodule

//--- rtl/ebc_ready_sync.sv
`timescale 1ns/1ps
module ebc_ready_sync
  import ebc_pkg::*;
(
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_arst_n,
  // Ready pin and setup
  input  wire logic i_ready,
  input  wire logic i_pol,
  input  wire logic i_async,
  output logic      o_ready
);

  logic norm;
  logic sync1;
  logic sync2;

  assign norm = (i_ready == i_pol);

  // ----------------------------------------
  // Async path costs two extra stages
  // ----------------------------------------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= norm;
      sync2 <= sync1;
    end
  end

  assign o_ready = i_async ? sync2 : norm; // RULE13

endmodule

//--- rtl/ebc_core.sv
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module ebc_core
  import ebc_pkg::*;
(
  // Clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_arst_n,
  // Avalon-MM slave
  input  wire logic [AVM_AW-1:0] i_avm_address,
  input  wire logic              i_avm_read,
  input  wire logic              i_avm_write,
  input  wire logic [31:0]       i_avm_writedata,
  output logic [31:0]            o_avm_readdata,
  output logic                   o_avm_waitrequest,
  // External bus
  output logic [ADDR_W-1:0]      o_address_lines,
  input  wire logic [DATA_W-1:0] i_shared_addr_data_lines,
  output logic [DATA_W-1:0]      o_shared_addr_data_lines,
  output logic                   o_shared_addr_data_oe,
  input  wire logic [DATA_W-1:0] i_dedicated_data_lines,
  output logic [DATA_W-1:0]      o_dedicated_data_lines,
  output logic                   o_dedicated_data_oe,
  output logic                   o_rd_n,
  output logic                   o_wr_n,
  output logic [NUM_CS-1:0]      o_cs_n,
  output logic                   o_ale,
  output logic                   o_high_byte_enable_n,
  input  wire logic              i_ready
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [TCFG_W-1:0] chip_select_timing_config [NUM_CS];
  logic [7:0]        presc;
  bus_req_s          req;
  logic [DATA_W-1:0] rdata;
  logic              busy;
  logic              done;
  phase_e            phase;
  logic [5:0]        left;
  logic [ADDR_W-WIN_LSB-1:0] last_win;
  logic              win_valid;
  logic              tick;
  logic              rdy;
  phase_cfg_s        cfg;
  logic [TCFG_W-1:0] raw;
  logic              cmd_hit;
  logic              win_chg;
  logic              last_unit;
  logic              ab_exit;
  logic              strobe_rise;
  phase_e            after_acc;

  ebc_time_unit u_time (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_presc  (presc),
    .i_clear  (cmd_hit),
    .o_tick   (tick)
  );

  assign raw = chip_select_timing_config[req.cs];
  // Phase lengths come from the selected chip select
  always_comb begin
    cfg.multiplexed_bus_mode       = raw[F_MUX];
    cfg.rdy_en    = raw[F_RDYE];
    cfg.rdy_pol   = raw[F_RDYP];
    cfg.rdy_async = raw[F_RDYA];
    cfg.len_ab    = 3'(raw[F_AB]) + 3'h1
                  + (win_chg ? 3'(raw[F_ABX+:2]) : 3'h0); // RULE2 RULE3
    cfg.len_c     = raw[F_C+:2]; // RULE4
    cfg.len_d     = raw[F_D]; // RULE5
    cfg.len_e     = 6'(raw[F_E+:5]) + 6'h01; // RULE6
    cfg.len_f     = raw[F_F+:2]; // RULE4
  end

  assign win_chg = !win_valid || (last_win != req.addr[ADDR_W-1:WIN_LSB]);

  ebc_ready_sync u_rdy (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_ready  (i_ready),
    .i_pol    (cfg.rdy_pol),
    .i_async  (cfg.rdy_async),
    .o_ready  (rdy)
  );

  // ----------------------------------------
  // Bus slave: one wait cycle, then answer
  // ----------------------------------------
  logic acc_pend;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acc_pend <= 1'b0;
    end else begin
      acc_pend <= (i_avm_read || i_avm_write) && !acc_pend;
    end
  end
  assign o_avm_waitrequest = (i_avm_read || i_avm_write) && !acc_pend;
  assign cmd_hit = i_avm_write && acc_pend && (i_avm_address == REG_CMD) && !busy;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < NUM_CS; i++) begin
        chip_select_timing_config[i] <= TCFG_RST;
      end
      presc <= PRESC_RST;
    end else if (i_avm_write && acc_pend) begin
      for (int i = 0; i < NUM_CS; i++) begin
        if (i_avm_address == REG_TIMING0 + AVM_AW'(4 * i)) begin
          chip_select_timing_config[i] <= i_avm_writedata[TCFG_W-1:0];
        end
      end
      if (i_avm_address == REG_PRESC) begin
        presc <= i_avm_writedata[7:0];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      req <= '0;
    end else if (i_avm_write && acc_pend && !busy) begin
      if (i_avm_address == REG_ADDR) begin
        req.addr <= i_avm_writedata[ADDR_W-1:0];
      end
      if (i_avm_address == REG_WDATA) begin
        req.wdata <= i_avm_writedata[DATA_W-1:0];
      end
      if (i_avm_address == REG_CMD) begin
        req.wr    <= i_avm_writedata[0];
        req.bhe_n <= i_avm_writedata[1];
        req.cs    <= i_avm_writedata[5:4];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_avm_readdata <= 32'h0000_0000;
    end else begin
      o_avm_readdata <= 32'h0000_0000;
      for (int i = 0; i < NUM_CS; i++) begin
        if (i_avm_address == REG_TIMING0 + AVM_AW'(4 * i)) begin
          o_avm_readdata <= 32'(chip_select_timing_config[i]);
        end
      end
      unique case (i_avm_address)
        REG_ADDR:   o_avm_readdata <= 32'(req.addr);
        REG_WDATA:  o_avm_readdata <= 32'(req.wdata);
        REG_STATUS: o_avm_readdata <= 32'({done, busy});
        REG_RDATA:  o_avm_readdata <= 32'(rdata);
        REG_PRESC:  o_avm_readdata <= 32'(presc);
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Phase sequencer
  // ----------------------------------------
  assign last_unit = (left <= 6'h01);
  // First tick in setup already counts as its first unit
  assign ab_exit   = (phase == PH_AB) && tick
                   && ((left == 6'h00) ? (cfg.len_ab <= 3'h1) : last_unit);
  // Zero-length hold ends the cycle at the access end
  assign after_acc = (cfg.len_f != 2'h0) ? PH_F : PH_IDLE;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase <= PH_IDLE;
      left  <= 6'h00;
      busy  <= 1'b0;
    end else if (phase == PH_IDLE) begin
      if (cmd_hit) begin
        busy  <= 1'b1;
        phase <= PH_AB; // RULE1
        left  <= 6'h00;
      end
    end else if (tick) begin // RULE15
      unique case (phase)
        PH_AB: begin
          if (ab_exit) begin
            // Zero-length phases are skipped, never stretched to a unit
            if (cfg.len_c != 2'h0) begin
              phase <= PH_C;
              left  <= 6'(cfg.len_c);
            end else if (cfg.len_d) begin
              phase <= PH_D;
              left  <= 6'(cfg.len_d);
            end else begin
              phase <= PH_E;
              left  <= cfg.len_e;
            end
          end else if (left == 6'h00) begin
            left <= 6'(cfg.len_ab) - 6'h01; // RULE3
          end else begin
            left <= left - 6'h01;
          end
        end
        PH_C: begin
          if (!last_unit) begin
            left <= left - 6'h01;
          end else if (cfg.len_d) begin
            phase <= PH_D;
            left  <= 6'(cfg.len_d);
          end else begin
            phase <= PH_E;
            left  <= cfg.len_e;
          end
        end
        PH_D: begin
          if (last_unit) begin
            phase <= PH_E;
            left  <= cfg.len_e;
          end else begin
            left <= left - 6'h01;
          end
        end
        PH_E: begin
          if (last_unit) begin
            phase <= cfg.rdy_en ? PH_RDY : after_acc; // RULE6
            left  <= 6'(cfg.len_f);
            busy  <= cfg.rdy_en || (after_acc != PH_IDLE);
          end else begin
            left <= left - 6'h01;
          end
        end
        PH_RDY: begin
          if (rdy) begin
            phase <= after_acc; // RULE12
            busy  <= (after_acc != PH_IDLE);
          end
        end
        PH_F: begin
          if (last_unit) begin
            phase <= PH_IDLE;
            busy  <= 1'b0;
          end else begin
            left <= left - 6'h01;
          end
        end
        default: phase <= PH_IDLE;
      endcase
    end
  end

  logic strobe_end;
  assign strobe_end = tick && ((phase == PH_E && last_unit && !cfg.rdy_en)
                    || (phase == PH_RDY && rdy));

  // ----------------------------------------
  // Read capture, window tracking, done flag
  // ----------------------------------------
  // Strobe pins lag the phase, so capture waits one clock for the rise
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata       <= 16'h0000;
      last_win    <= '0;
      win_valid   <= 1'b0;
      done        <= 1'b0;
      strobe_rise <= 1'b0;
    end else begin
      strobe_rise <= strobe_end;
      if (strobe_rise && !req.wr) begin
        rdata <= cfg.multiplexed_bus_mode ? i_shared_addr_data_lines
                         : i_dedicated_data_lines; // RULE7
      end
      if (ab_exit) begin
        last_win  <= req.addr[ADDR_W-1:WIN_LSB];
        win_valid <= 1'b1;
      end
      if (strobe_rise) begin
        done <= 1'b1;
      end else if (cmd_hit) begin
        done <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Pin drive, all registered
  // ----------------------------------------
  logic in_cmd;
  assign in_cmd = (phase == PH_E || phase == PH_RDY);

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_address_lines          <= '0;
      o_shared_addr_data_lines <= '0;
      o_shared_addr_data_oe    <= 1'b0;
      o_dedicated_data_lines   <= '0;
      o_dedicated_data_oe      <= 1'b0;
      o_rd_n                   <= 1'b1;
      o_wr_n                   <= 1'b1;
      o_cs_n                   <= '1;
      o_ale                    <= 1'b0;
      o_high_byte_enable_n     <= 1'b1;
    end else begin
      o_address_lines      <= req.addr; // RULE11
      o_high_byte_enable_n <= (phase == PH_IDLE) ? 1'b1 : req.bhe_n;
      o_cs_n               <= '1;
      if (phase != PH_IDLE) begin
        o_cs_n[req.cs] <= 1'b0;
      end
      o_ale  <= (phase == PH_AB);
      o_rd_n <= !(in_cmd && !req.wr);
      o_wr_n <= !(in_cmd && req.wr);
      // Address first, write data later on shared lines
      o_shared_addr_data_oe    <= cfg.multiplexed_bus_mode && (phase == PH_AB
                               || (req.wr && (in_cmd || phase == PH_F
                               || (phase == PH_D)))); // RULE9
      o_shared_addr_data_lines <= (phase == PH_AB) ? req.addr[DATA_W-1:0]
                                                   : req.wdata; // RULE9
      o_dedicated_data_oe      <= !cfg.multiplexed_bus_mode && req.wr && (phase == PH_D
                               || in_cmd || phase == PH_F); // RULE10
      o_dedicated_data_lines   <= req.wdata; // RULE10
    end
  end

endmodule

//--- test/ebc_core_sva.sv
`timescale 1ns/1ps
module ebc_core_sva
  import ebc_pkg::*;
(
  // Clock and reset
  input wire logic              i_mclk,
  input wire logic              i_arst_n,
  // External bus
  input wire logic [ADDR_W-1:0] o_address_lines,
  input wire logic [DATA_W-1:0] o_shared_addr_data_lines,
  input wire logic              o_shared_addr_data_oe,
  input wire logic [DATA_W-1:0] o_dedicated_data_lines,
  input wire logic              o_dedicated_data_oe,
  input wire logic              o_rd_n,
  input wire logic              o_wr_n,
  input wire logic [NUM_CS-1:0] o_cs_n,
  input wire logic              o_ale
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // ----------------------------------------
  // Cycle shape
  // ----------------------------------------
  property p_one_strobe;
    !(!o_rd_n && !o_wr_n);
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
  property p_ale_first;
    o_ale |-> o_rd_n && o_wr_n;
  endproperty
  a_ale_first: assert property (p_ale_first) else $error("strobe during setup");
  property p_one_cs;
    $onehot0(~o_cs_n);
  endproperty
  a_one_cs: assert property (p_one_cs) else $error("several selects");
  property p_cs_strobe;
    !(o_rd_n && o_wr_n) |-> !(&o_cs_n);
  endproperty
  a_cs_strobe: assert property (p_cs_strobe) else $error("strobe without select");
  // ----------------------------------------
  // Data and address
  // ----------------------------------------
  property p_addr_hold;
    !o_rd_n && !$past(o_rd_n) |-> $stable(o_address_lines) && $stable(o_cs_n);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in read");
  property p_rd_release;
    !o_rd_n |-> !o_shared_addr_data_oe && !o_dedicated_data_oe;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("driving during read");
  property p_wr_drive;
    !o_wr_n |-> o_shared_addr_data_oe || o_dedicated_data_oe;
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write data not driven");
  // Data must not move under the write strobe
  property p_wr_stable;
    !o_wr_n && !$past(o_wr_n) |->
      $stable(o_shared_addr_data_lines) && $stable(o_dedicated_data_lines);
  endproperty
  a_wr_stable: assert property (p_wr_stable) else $error("write data moved");
  c_read: cover property ($rose(o_rd_n));
  c_mux_wr: cover property (!o_wr_n && o_shared_addr_data_oe);
  c_setup: cover property ($fell(o_ale));
endmodule

//--- test/ebc_ext_mem.sv
`timescale 1ns/1ps
module ebc_ext_mem
  import ebc_pkg::*;
(
  // Bus side
  input  wire logic              i_mclk,
  input  wire logic              i_mux,
  input  wire logic              i_ale,
  input  wire logic              i_rd_n,
  input  wire logic              i_wr_n,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_ad,
  input  wire logic [DATA_W-1:0] i_d,
  // Handshake setup
  input  wire logic [3:0]        i_rdy_wait,
  input  wire logic              i_rdy_pol,
  // Answers
  output logic [DATA_W-1:0]      o_data,
  output logic                   o_ready
);
  logic [DATA_W-1:0] mem [256];
  logic [7:0]        lat;
  logic [7:0]        idx;
  logic [3:0]        cnt;
  logic              act;
  assign idx = i_mux ? lat : i_addr[7:0];
  always @(posedge i_mclk) begin
    if (i_ale) lat <= i_ad[7:0];
    if (!i_wr_n) mem[idx] <= i_mux ? i_ad : i_d;
    cnt <= (i_rd_n && i_wr_n) ? 4'h0 : cnt + {3'h0, cnt != 4'hF};
  end
  // Inverted word after strobe rise, so stale data never passes
  assign o_data = !i_rd_n ? mem[idx] : ~mem[idx];
  // Ready dropped as soon as the strobe rises
  assign act = !(i_rd_n && i_wr_n) && cnt >= i_rdy_wait;
  assign o_ready = act ~^ i_rdy_pol;
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
  import ebc_pkg::*;
  logic              i_mclk, i_arst_n, i_avm_read, i_avm_write;
  logic [AVM_AW-1:0] i_avm_address;
  logic [31:0]       i_avm_writedata, o_avm_readdata;
  logic              o_avm_waitrequest, o_shared_addr_data_oe, o_dedicated_data_oe;
  logic [ADDR_W-1:0] o_address_lines;
  logic [DATA_W-1:0] o_shared_addr_data_lines, o_dedicated_data_lines, mem_data;
  logic              o_rd_n, o_wr_n, o_ale, o_high_byte_enable_n, i_ready;
  logic [NUM_CS-1:0] o_cs_n;
  logic              mux_mode, rdy_pol, run, stb_q, ale_q;
  logic [3:0]        rdy_wait;
  int                errors, samples_checked, ale_len, cmd_len;
  logic [DATA_W-1:0] ale_ad, wr_ad;
  logic [ADDR_W-1:0] stb_addr;
  logic [NUM_CS:0]   stb_ctl;
  wire logic [DATA_W-1:0] i_shared_addr_data_lines =
    o_shared_addr_data_oe ? o_shared_addr_data_lines : mem_data;
  wire logic [DATA_W-1:0] i_dedicated_data_lines =
    o_dedicated_data_oe ? o_dedicated_data_lines : mem_data;
  ebc_core i_ebc_core (.i_mclk, .i_arst_n, .i_avm_address, .i_avm_read, .i_avm_write,
    .i_avm_writedata, .o_avm_readdata, .o_avm_waitrequest, .o_address_lines,
    .i_shared_addr_data_lines, .o_shared_addr_data_lines, .o_shared_addr_data_oe,
    .i_dedicated_data_lines, .o_dedicated_data_lines, .o_dedicated_data_oe, .o_rd_n,
    .o_wr_n, .o_cs_n, .o_ale, .o_high_byte_enable_n, .i_ready);
  ebc_ext_mem i_ebc_ext_mem (.i_mclk(i_mclk), .i_mux(mux_mode), .i_ale(o_ale),
    .i_rd_n(o_rd_n), .i_wr_n(o_wr_n), .i_addr(o_address_lines),
    .i_ad(o_shared_addr_data_lines), .i_d(o_dedicated_data_lines),
    .i_rdy_wait(rdy_wait), .i_rdy_pol(rdy_pol), .o_data(mem_data), .o_ready(i_ready));
  // ----------------------------------------
  // Pin monitor: phase lengths in clocks
  // ----------------------------------------
  always @(posedge i_mclk) begin
    ale_q <= o_ale;
    stb_q <= !(o_rd_n && o_wr_n);
    if (o_ale) begin
      ale_len <= ale_q ? ale_len + 1 : 1;
      ale_ad <= o_shared_addr_data_lines;
      cmd_len <= 0;
      run <= 1'b1;
    end else if (run) begin
      if (stb_q && o_rd_n && o_wr_n) run <= 1'b0;
      else cmd_len <= cmd_len + 1;
    end
    if (!o_wr_n) wr_ad <= o_shared_addr_data_lines;
    if (!(o_rd_n && o_wr_n)) stb_ctl <= {o_high_byte_enable_n, o_cs_n};
    if (!(o_rd_n && o_wr_n)) stb_addr <= o_address_lines;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic avm(input logic w, input logic [AVM_AW-1:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_avm_address <= a;
    i_avm_writedata <= d;
    i_avm_write <= w;
    i_avm_read <= !w;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_avm_waitrequest !== 1'b0 && n < 50);
    q = o_avm_readdata;
    i_avm_write <= 1'b0;
    i_avm_read <= 1'b0;
    if (o_avm_waitrequest !== 1'b0) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [AVM_AW-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    avm(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [AVM_AW-1:0] a, output logic [31:0] q);
    avm(1'b0, a, 32'h0, q);
  endtask
  function automatic logic [31:0] cfg(input logic ab, input logic [1:0] abx, c,
      input logic d, input logic [4:0] e, input logic [1:0] f, input logic [3:0] m);
    return {15'h0, m, f, e, d, c, abx, ab};
  endfunction
  // One external access; high byte enable follows direction
  task automatic acc(input logic [1:0] cs, input logic w, input logic [23:0] a,
                     input logic [15:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wr(REG_ADDR, {8'h00, a});
    wr(REG_WDATA, {16'h0000, d});
    wr(REG_CMD, {26'h0, cs, 2'h0, w, w});
    do begin
      rd(REG_STATUS, q);
      n++;
    end while (q[1] !== 1'b1 && n < 400);
    if (q[1] !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
    rd(REG_RDATA, q);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [31:0] q;
    rd(REG_TIMING0, q);
    chk(q, {15'h0, TCFG_RST});
    rd(REG_PRESC, q);
    chk(q, {24'h0, PRESC_RST});
    wr(6'h3C, 32'hFFFFFFFF);
    rd(6'h3C, q);
    chk(q, 32'h0);
    $display("test reset done");
  endtask
  // Two clocks per unit; first access and window change add three units
  task automatic t_phase;
    logic [31:0] q;
    wr(REG_PRESC, 32'h1);
    wr(6'h04, cfg(1'b1, 2'h3, 2'h2, 1'b1, 5'h3, 2'h1, 4'h0));
    acc(2'h1, 1'b1, 24'h120010, 16'hA55A, q);
    chk(ale_len, 10);
    chk(cmd_len, 14);
    chk(stb_addr, 24'h120010);
    chk(stb_ctl, 5'h1D);
    acc(2'h1, 1'b0, 24'h120010, 16'h0, q);
    chk(q, 32'hA55A);
    chk(ale_len, 4);
    chk(cmd_len, 14);
    chk(stb_ctl, 5'h0D);
    acc(2'h1, 1'b1, 24'h340020, 16'h1234, q);
    chk(ale_len, 10);
    $display("test phase done");
  endtask
  task automatic t_mux;
    logic [31:0] q;
    wr(REG_PRESC, 32'h0);
    mux_mode = 1'b1;
    wr(6'h08, cfg(1'b0, 2'h0, 2'h1, 1'b0, 5'h1, 2'h2, 4'h1));
    acc(2'h2, 1'b1, 24'h340055, 16'hC3E1, q);
    chk(ale_ad, 32'h0055);
    chk(wr_ad, 32'hC3E1);
    chk(cmd_len, 3);
    acc(2'h2, 1'b0, 24'h340055, 16'h0, q);
    chk(q, 32'hC3E1);
    chk(ale_len, 1);
    mux_mode = 1'b0;
    $display("test mux done");
  endtask
  // Module holds ready off for six strobe cycles
  task automatic t_ready;
    logic [31:0] q;
    logic [3:0]  md [3] = '{4'h6, 4'h2, 4'hE};
    foreach (md[k]) begin
      rdy_pol = md[k][2];
      wr(6'h0C, cfg(1'b0, 2'h0, 2'h0, 1'b0, 5'h0, 2'h0, md[k]));
      acc(2'h3, 1'b1, 24'h340040 + 24'(k), 16'h5A00 + 16'(k), q);
      acc(2'h3, 1'b0, 24'h340040 + 24'(k), 16'h0, q);
      chk(q, 32'h5A00 + 32'(k));
      chk(cmd_len, md[k][3] ? 32'd10 : 32'd8);
    end
    rdy_pol = 1'b1;
    $display("test ready done");
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  initial begin
    i_arst_n = 1'b0;
    i_avm_address = '0;
    i_avm_read = 1'b0;
    i_avm_write = 1'b0;
    i_avm_writedata = '0;
    {mux_mode, rdy_pol, rdy_wait, run, stb_q, ale_q} = {2'b01, 4'h6, 3'b000};
    errors = 0;
    samples_checked = 0;
    repeat (2) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    t_reset();
    t_phase();
    t_mux();
    t_ready();
    tally_and_finish();
  end
endmodule
bind ebc_core ebc_core_sva i_ebc_core_sva (.i_mclk, .i_arst_n, .o_address_lines,
  .o_shared_addr_data_lines, .o_shared_addr_data_oe, .o_dedicated_data_lines,
  .o_dedicated_data_oe, .o_rd_n, .o_wr_n, .o_cs_n, .o_ale);
